// ---- rtl/pulser_pkg.sv ----
// Purpose: Shared constants and types for the multi-channel output pulser.
// Assumes: One clock; samples advance on a divided enable pulse.
// Notes:   Mode codes are the encoding of the control_mode ports.
package pulser_pkg;
   localparam int          NUM_CHAN    = 8;
   localparam int          SAMPLE_W    = 16;
   localparam int          DUR_W       = 32;
   localparam int          TS_W        = 32;
   localparam int          WAVE_DEPTH  = 64;
   localparam int          WAVE_AW     = 6;
   localparam int          LEN_W       = 7;
   localparam int          CHAN_AW     = 3;
   // Clock cycles per sample period.
   localparam logic [7:0]  SAMPLE_DIV  = 8'h14;
   // A logged pulse needs more than this many high samples to log its end.
   localparam logic [1:0]  LOG_OFF_MIN = 2'h2;
   localparam logic [1:0]  MODE_STROBED   = 2'h0;
   localparam logic [1:0]  MODE_TRIGGERED = 2'h1;
   localparam logic [1:0]  MODE_WAVE      = 2'h2;
   localparam logic [7:0]  DIV_RESET   = 8'h00;
   localparam logic [31:0] TS_RESET    = 32'h0;
   typedef enum logic [1:0] {CH_IDLE, CH_STROBE, CH_TRIG, CH_PLAY} chan_state_e;
endpackage

// ---- rtl/pulse_wave_if.sv ----
// Purpose: Carries waveform loads and per-channel reads to the wave buffer.
// Assumes: Reads are combinational, writes take one clock.
// Notes:   One read port per channel.
`timescale 1ns/10ps
interface pulse_wave_if;
   logic                                                   wr_en;
   logic [pulser_pkg::CHAN_AW-1:0]                        wr_chan;
   logic [pulser_pkg::WAVE_AW-1:0]                        wr_addr;
   logic [pulser_pkg::SAMPLE_W-1:0]                       wr_data;
   logic [pulser_pkg::NUM_CHAN-1:0][pulser_pkg::WAVE_AW-1:0]  rd_addr;
   logic [pulser_pkg::NUM_CHAN-1:0][pulser_pkg::SAMPLE_W-1:0] rd_data;
   modport user (output wr_en, wr_chan, wr_addr, wr_data, rd_addr, input rd_data);
   modport store (input wr_en, wr_chan, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

// ---- rtl/wave_buffer.sv ----
// Purpose: Holds one custom waveform per channel.
// Assumes: Loader writes one sample per clock.
// Notes:   Contents are not cleared by reset; an unloaded entry reads as unknown.
`timescale 1ns/10ps
module wave_buffer (
   // Clock and reset.
   input wire logic    clk,
   input wire logic    rst,
   // Load and play access.
   pulse_wave_if.store wb
);
   logic [pulser_pkg::SAMPLE_W-1:0] mem [pulser_pkg::NUM_CHAN][pulser_pkg::WAVE_DEPTH];

   // Memory write; reset only blocks writes, so a loaded waveform survives it.
   always_ff @(posedge clk) begin
      if (wb.wr_en && !rst) begin
         mem[wb.wr_chan][wb.wr_addr] <= wb.wr_data;
      end
   end

   // Each channel reads its own waveform at its own play index.
   always_comb begin
      for (int c = 0; c < pulser_pkg::NUM_CHAN; c++) begin
         wb.rd_data[c] = mem[c][wb.rd_addr[c]];
      end
   end
endmodule

// ---- rtl/output_pulser.sv ----
// Purpose: Bank of output channels: strobed levels, timed pulses, waveform playback, logging.
// Assumes: Commands are one-cycle pulses; configuration is stable while a channel is busy.
// Notes:   Samples advance on sample_tick; commands wait for the next sample.
// What this block does
// - Up to eight channels, each with own mode, duration, level and logging.
// - Triggered mode: high on trigger, held for duration samples by hardware.
// - Duration zero gives exactly one high sample.
// - Strobed mode: assert raises, deassert lowers, level held between them.
// - Logging enabled: timestamp recorded on the sample a channel turns on.
// - High more than two samples also logs the turn-off time.
// - Loaded waveform plays out in order, one sample per period, on trigger.
`timescale 1ns/10ps
module output_pulser (
   // Clock and reset.
   input  wire logic                               clk,
   input  wire logic                               rst,
   // Commands, one bit per channel, one-cycle pulses.
   input  wire logic [7:0]                         trigger_command,
   input  wire logic [7:0]                         assert_command,
   input  wire logic [7:0]                         deassert_command,
   // Per-channel configuration.
   input  wire logic [7:0]                         chan_enable,
   input  wire logic [7:0][1:0]                    control_mode,
   input  wire logic [7:0][31:0]                   duration,
   input  wire logic [7:0][15:0]                   high_value,
   input  wire logic [7:0][6:0]                    wave_length,
   input  wire logic [7:0]                         log_enable,
   // Waveform load.
   input  wire logic                               wave_wr_en,
   input  wire logic [2:0]                         wave_wr_chan,
   input  wire logic [5:0]                         wave_wr_addr,
   input  wire logic [15:0]                        wave_wr_data,
   // Channel outputs and status.
   output      logic [7:0][15:0]                   chan_out,
   output      logic [7:0]                         chan_active,
   output      logic                               sample_tick,
   output      logic [31:0]                        sample_count,
   // Event log.
   output      logic [7:0]                         log_on_strobe,
   output      logic [7:0]                         log_off_strobe,
   output      logic [31:0]                        log_time
);
   localparam int N = pulser_pkg::NUM_CHAN;

   pulse_wave_if wif ();

   logic [7:0]                    div_reg, div_next;
   logic                          tick_reg, tick_next;
   logic [31:0]                   cnt_reg, cnt_next;
   logic [N-1:0]                  ptrig_reg, ptrig_next, pasrt_reg, pasrt_next;
   logic [N-1:0]                  pdasrt_reg, pdasrt_next;
   logic [N-1:0]                  trig_eff, asrt_eff, dasrt_eff;
   pulser_pkg::chan_state_e       state_reg [N];
   pulser_pkg::chan_state_e       state_next [N];
   logic [N-1:0][31:0]            remain_reg, remain_next;
   logic [N-1:0][6:0]             idx_reg, idx_next;
   logic [N-1:0][1:0]             hi_reg, hi_next;
   logic [N-1:0][15:0]            out_reg, out_next;
   logic [N-1:0]                  on_ev, off_ev;
   logic [N-1:0]                  lon_reg, lon_next, loff_reg, loff_next;
   logic [31:0]                   ltime_reg, ltime_next;

   // Zero counts as one, for durations and wave lengths alike.
   function automatic logic [31:0] at_least_one(input logic [31:0] v);
      return (v == 32'h0) ? 32'h1 : v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Sample divider and sample counter.
   always_comb begin
      tick_next = (div_reg == pulser_pkg::SAMPLE_DIV - 8'h01);
      div_next  = tick_next ? pulser_pkg::DIV_RESET : div_reg + 8'h01;
      cnt_next  = tick_reg ? cnt_reg + 32'h1 : cnt_reg;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         div_reg  <= pulser_pkg::DIV_RESET;
         tick_reg <= 1'b0;
         cnt_reg  <= pulser_pkg::TS_RESET;
      end else begin
         div_reg  <= div_next;
         tick_reg <= tick_next;
         cnt_reg  <= cnt_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command latches. A command in the tick cycle acts at once, so none is lost.
   always_comb begin
      trig_eff    = ptrig_reg | trigger_command;
      asrt_eff    = pasrt_reg | assert_command;
      dasrt_eff   = pdasrt_reg | deassert_command;
      ptrig_next  = tick_reg ? '0 : trig_eff;
      pasrt_next  = tick_reg ? '0 : asrt_eff;
      pdasrt_next = tick_reg ? '0 : dasrt_eff;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ptrig_reg  <= '0;
         pasrt_reg  <= '0;
         pdasrt_reg <= '0;
      end else begin
         ptrig_reg  <= ptrig_next;
         pasrt_reg  <= pasrt_next;
         pdasrt_reg <= pdasrt_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Waveform buffer hookup; a playing channel reads at its index, others at 0.
   assign wif.wr_en   = wave_wr_en;
   assign wif.wr_chan = wave_wr_chan;
   assign wif.wr_addr = wave_wr_addr;
   assign wif.wr_data = wave_wr_data;
   always_comb begin
      for (int c = 0; c < N; c++) begin
         wif.rd_addr[c] = (state_reg[c] == pulser_pkg::CH_PLAY) ? idx_reg[c][5:0] : 6'h0;
      end
   end

   wave_buffer u_wave (
      .clk (clk),
      .rst (rst),
      .wb  (wif.store)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Channel state machines, all stepping on the same sample tick.
   always_comb begin
      for (int c = 0; c < N; c++) begin
         state_next[c]  = state_reg[c];
         remain_next[c] = remain_reg[c];
         idx_next[c]    = idx_reg[c];
         if (tick_reg) begin
            unique case (state_reg[c])
               pulser_pkg::CH_IDLE: begin
                  if (trig_eff[c] && control_mode[c] == pulser_pkg::MODE_TRIGGERED) begin
                     state_next[c]  = pulser_pkg::CH_TRIG;
                     remain_next[c] = at_least_one(duration[c]) - 32'h1;
                  end else if (trig_eff[c] && control_mode[c] == pulser_pkg::MODE_WAVE) begin
                     state_next[c] = pulser_pkg::CH_PLAY;
                     idx_next[c]   = 7'h01;
                  end else if (asrt_eff[c] && control_mode[c] == pulser_pkg::MODE_STROBED) begin
                     state_next[c] = pulser_pkg::CH_STROBE;
                  end
               end
               pulser_pkg::CH_TRIG: begin
                  // A new trigger restarts the pulse; otherwise count it down.
                  if (trig_eff[c]) begin
                     remain_next[c] = at_least_one(duration[c]) - 32'h1;
                  end else if (remain_reg[c] == 32'h0) begin
                     state_next[c] = pulser_pkg::CH_IDLE;
                  end else begin
                     remain_next[c] = remain_reg[c] - 32'h1;
                  end
               end
               pulser_pkg::CH_STROBE: begin
                  if (dasrt_eff[c]) begin
                     state_next[c] = pulser_pkg::CH_IDLE;
                  end
               end
               pulser_pkg::CH_PLAY: begin
                  // Triggers during playback are ignored to keep the sample order intact.
                  if ({25'h0, idx_reg[c]} >= at_least_one({25'h0, wave_length[c]})) begin
                     state_next[c] = pulser_pkg::CH_IDLE;
                  end else begin
                     idx_next[c] = idx_reg[c] + 7'h01;
                  end
               end
            endcase
            if (!chan_enable[c]) begin
               state_next[c] = pulser_pkg::CH_IDLE;
            end
         end
      end
   end

   // Output value, high-sample count and log events follow the next state.
   always_comb begin
      for (int c = 0; c < N; c++) begin
         out_next[c] = out_reg[c];
         hi_next[c]  = hi_reg[c];
         on_ev[c]    = 1'b0;
         off_ev[c]   = 1'b0;
         if (tick_reg) begin
            unique case (state_next[c])
               pulser_pkg::CH_IDLE: out_next[c] = 16'h0;
               pulser_pkg::CH_PLAY: out_next[c] = wif.rd_data[c];
               default:             out_next[c] = high_value[c];
            endcase
            if (state_next[c] == pulser_pkg::CH_IDLE) begin
               hi_next[c] = 2'h0;
            end else if (hi_reg[c] != 2'h3) begin
               hi_next[c] = hi_reg[c] + 2'h1;
            end
            on_ev[c]  = state_reg[c] == pulser_pkg::CH_IDLE &&
                        state_next[c] != pulser_pkg::CH_IDLE;
            off_ev[c] = state_reg[c] != pulser_pkg::CH_IDLE &&
                        state_next[c] == pulser_pkg::CH_IDLE &&
                        hi_reg[c] > pulser_pkg::LOG_OFF_MIN;
         end
      end
      lon_next   = on_ev & log_enable;
      loff_next  = off_ev & log_enable;
      ltime_next = ((on_ev | off_ev) & log_enable) != '0 ? cnt_reg : ltime_reg;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int c = 0; c < N; c++) begin
            state_reg[c] <= pulser_pkg::CH_IDLE;
         end
         remain_reg <= '0;
         idx_reg    <= '0;
         hi_reg     <= '0;
         out_reg    <= '0;
         lon_reg    <= '0;
         loff_reg   <= '0;
         ltime_reg  <= pulser_pkg::TS_RESET;
      end else begin
         state_reg  <= state_next;
         remain_reg <= remain_next;
         idx_reg    <= idx_next;
         hi_reg     <= hi_next;
         out_reg    <= out_next;
         lon_reg    <= lon_next;
         loff_reg   <= loff_next;
         ltime_reg  <= ltime_next;
      end
   end

   // Registered outputs, except chan_active, decoded from state_reg.
   always_comb begin
      for (int c = 0; c < N; c++) begin
         chan_active[c] = state_reg[c] != pulser_pkg::CH_IDLE;
      end
   end
   assign chan_out       = out_reg;
   assign sample_tick    = tick_reg;
   assign sample_count   = cnt_reg;
   assign log_on_strobe  = lon_reg;
   assign log_off_strobe = loff_reg;
   assign log_time       = ltime_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks, one set per channel.
   for (genvar g = 0; g < N; g++) begin : g_chk
      sequence seq_trig_start;
         tick_reg && chan_enable[g] && state_reg[g] == pulser_pkg::CH_IDLE &&
         trig_eff[g] && control_mode[g] == pulser_pkg::MODE_TRIGGERED;
      endsequence
      sequence seq_trig_last;
         tick_reg && state_reg[g] == pulser_pkg::CH_TRIG && remain_reg[g] == 32'h0 &&
         !trig_eff[g];
      endsequence
      AST_IDLE_ZERO: assert property (@(posedge clk) disable iff (rst)
         state_reg[g] == pulser_pkg::CH_IDLE |-> out_reg[g] == 16'h0)
         else $error("Idle channel drives a nonzero sample");
      AST_TRIG_ZERO: assert property (@(posedge clk) disable iff (rst)
         seq_trig_start ##0 duration[g] == 32'h0 |=> state_reg[g] == pulser_pkg::CH_TRIG
         && remain_reg[g] == 32'h0)
         else $error("Zero duration does not give a single sample");
      AST_TRIG_END: assert property (@(posedge clk) disable iff (rst)
         seq_trig_last |=> state_reg[g] == pulser_pkg::CH_IDLE && out_reg[g] == 16'h0)
         else $error("Triggered pulse does not end on time");
      AST_TRIG_LOAD: assert property (@(posedge clk) disable iff (rst)
         seq_trig_start ##0 chan_enable[g] |=> remain_reg[g] ==
         at_least_one($past(duration[g])) - 32'h1 && out_reg[g] == $past(high_value[g]))
         else $error("Triggered pulse not loaded with its duration");
      AST_STROBE_HOLD: assert property (@(posedge clk) disable iff (rst)
         state_reg[g] == pulser_pkg::CH_STROBE && !tick_reg |=> $stable(out_reg[g]) &&
         state_reg[g] == pulser_pkg::CH_STROBE)
         else $error("Strobed level changed between samples");
      AST_STROBE_OFF: assert property (@(posedge clk) disable iff (rst)
         tick_reg && state_reg[g] == pulser_pkg::CH_STROBE && dasrt_eff[g] |=>
         state_reg[g] == pulser_pkg::CH_IDLE ##[19:21] tick_reg)
         else $error("Deassert did not lower the channel");
      AST_LOG_ON: assert property (@(posedge clk) disable iff (rst)
         on_ev[g] && log_enable[g] |=> lon_reg[g] && ltime_reg == $past(cnt_reg))
         else $error("Onset not logged with its sample time");
      AST_LOG_SHORT: assert property (@(posedge clk) disable iff (rst)
         tick_reg && state_next[g] == pulser_pkg::CH_IDLE && hi_reg[g] <= 2'h2 |=>
         !loff_reg[g])
         else $error("Short pulse logged a turn-off");
      AST_PLAY_ORDER: assert property (@(posedge clk) disable iff (rst)
         tick_reg && state_reg[g] == pulser_pkg::CH_PLAY && state_next[g] ==
         pulser_pkg::CH_PLAY |=> out_reg[g] == $past(wif.rd_data[g]) &&
         idx_reg[g] == $past(idx_reg[g]) + 7'h01)
         else $error("Waveform sample out of order");
   end
endmodule

// ---- tb/pulse_controller_model.sv ----
// Purpose: Behavioural controller that issues channel commands and loads waveforms.
// Assumes: Called from the bench through tasks; every change lands on a falling edge.
// Notes:   Commands are one-cycle pulses; idle write data is scrambled on purpose.
`timescale 1ns/10ps
module pulse_controller_model (
   // Clock.
   input  wire logic        clk,
   // Commands to the pulser.
   output      logic [7:0]  trigger_command,
   output      logic [7:0]  assert_command,
   output      logic [7:0]  deassert_command,
   // Waveform load.
   output      logic        wave_wr_en,
   output      logic [2:0]  wave_wr_chan,
   output      logic [5:0]  wave_wr_addr,
   output      logic [15:0] wave_wr_data
);
   // Everything starts quiet so that no command is seen before reset ends.
   initial begin
      trigger_command  = 8'h00;
      assert_command   = 8'h00;
      deassert_command = 8'h00;
      wave_wr_en       = 1'b0;
      wave_wr_chan     = 3'h0;
      wave_wr_addr     = 6'h00;
      wave_wr_data     = 16'h0000;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Raises one command bit for one clock; kind 0 is trigger, 1 assert, 2 deassert.
   task automatic send(input int kind, input int ch);
      @(negedge clk);
      case (kind)
         0: trigger_command[ch] = 1'b1;
         1: assert_command[ch] = 1'b1;
         default: deassert_command[ch] = 1'b1;
      endcase
      @(negedge clk);
      trigger_command  = 8'h00;
      assert_command   = 8'h00;
      deassert_command = 8'h00;
   endtask
   // Writes four words on back-to-back clocks; data is inverted once idle so stale
   // values cannot pass for good ones.
   task automatic load(input logic [2:0] ch, input logic [15:0] w [4]);
      for (int i = 0; i < 4; i++) begin
         @(negedge clk);
         wave_wr_en   = 1'b1;
         wave_wr_chan = ch;
         wave_wr_addr = 6'(i);
         wave_wr_data = w[i];
      end
      @(negedge clk);
      wave_wr_en   = 1'b0;
      wave_wr_data = ~wave_wr_data;
   endtask
endmodule

// ---- tb/tb_output_pulser.sv ----
// Purpose: Self-checking bench for the output pulser, driven through the controller model.
// Assumes: Configuration is set once at time zero and held.
// Notes:   Outputs are sampled one cycle after each sample tick, where they settle.
`timescale 1ns/10ps
module tb_output_pulser;
   logic                clk;
   logic                rst;
   logic [7:0]          trigger_command, assert_command, deassert_command;
   logic [7:0]          chan_enable, log_enable, chan_active;
   logic [7:0][1:0]     control_mode;
   logic [7:0][31:0]    duration;
   logic [7:0][15:0]    high_value, chan_out;
   logic [7:0][6:0]     wave_length;
   logic                wave_wr_en, sample_tick;
   logic [2:0]          wave_wr_chan;
   logic [5:0]          wave_wr_addr;
   logic [15:0]         wave_wr_data;
   logic [31:0]         sample_count, log_time, ticks;
   logic [7:0]          log_on_strobe, log_off_strobe;
   logic [15:0]         w [4];
   int                  bad_count, cmp_count, gap;

   // Free-running 250 MHz clock.
   initial clk = 1'b0;
   always #2 clk = ~clk;

   pulse_controller_model ctl (.clk(clk), .trigger_command(trigger_command),
      .assert_command(assert_command), .deassert_command(deassert_command),
      .wave_wr_en(wave_wr_en), .wave_wr_chan(wave_wr_chan), .wave_wr_addr(wave_wr_addr),
      .wave_wr_data(wave_wr_data));
   output_pulser DUT (.clk(clk), .rst(rst), .trigger_command(trigger_command),
      .assert_command(assert_command), .deassert_command(deassert_command),
      .chan_enable(chan_enable), .control_mode(control_mode), .duration(duration),
      .high_value(high_value), .wave_length(wave_length), .log_enable(log_enable),
      .wave_wr_en(wave_wr_en), .wave_wr_chan(wave_wr_chan), .wave_wr_addr(wave_wr_addr),
      .wave_wr_data(wave_wr_data), .chan_out(chan_out), .chan_active(chan_active),
      .sample_tick(sample_tick), .sample_count(sample_count),
      .log_on_strobe(log_on_strobe), .log_off_strobe(log_off_strobe), .log_time(log_time));

   // Own tally of ticks, so the timestamp is predicted without reading it back.
   // Counted on the falling edge, where the tick pulse has settled.
   always @(negedge clk) begin
      if (rst) ticks <= 32'h0;
      else if (sample_tick === 1'b1) ticks <= ticks + 32'h1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Waits, bounded, for the next tick and then one clock, where new samples show.
   task automatic next_sample;
      gap = 0;
      do begin
         @(negedge clk);
         gap++;
      end while (sample_tick !== 1'b1 && gap < 40);
      if (gap >= 40) check("sample_tick", 32'h0, 32'h1);
      @(negedge clk);
      check("sample_count", sample_count, ticks);
   endtask
   task automatic expect_out(input int c, input logic [15:0] v, input logic on, input logic off);
      check("chan_out", 32'(chan_out[c]), 32'(v));
      check("chan_active", 32'(chan_active[c]), 32'(v != 16'h0));
      check("log_on_strobe", 32'(log_on_strobe[c]), 32'(on));
      check("log_off_strobe", 32'(log_off_strobe[c]), 32'(off));
      // The stamp is the count of the sample in which the change was decided.
      if (on || off) check("log_time", log_time, ticks - 32'h1);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog, far beyond the roughly twenty sample periods the tests need.
   initial begin
      #60000;
      check("watchdog", 32'h0, 32'h1);
      complete_run();
   end
   initial begin
      int c, hi;
      int tch [3] = '{1, 2, 5};
      rst = 1'b1;
      chan_enable = 8'hef; // Channel 4 disabled.
      log_enable = 8'h27;
      control_mode = '{default: pulser_pkg::MODE_TRIGGERED};
      control_mode[0] = pulser_pkg::MODE_STROBED;
      control_mode[3] = pulser_pkg::MODE_WAVE;
      control_mode[6] = 2'h3;
      control_mode[7] = pulser_pkg::MODE_STROBED;
      duration = '{default: 32'h0};
      duration[1] = 32'h3;
      duration[5] = 32'h2;
      high_value = '{16'h8888, 16'h7777, 16'h6666, 16'h5555, 16'h4444, 16'h3333,
                     16'h2222, 16'h1111};
      wave_length = '{default: 7'h00};
      wave_length[3] = 7'h04;
      w = '{16'h0a01, 16'h0b02, 16'h0c03, 16'h0d04};
      repeat (4) @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 8; i++) expect_out(i, 16'h0, 1'b0, 1'b0);
      // Strobed: raise, hold, lower, then a deassert while low changes nothing.
      ctl.send(1, 0);
      next_sample;
      expect_out(0, 16'h1111, 1'b1, 1'b0);
      repeat (2) begin
         next_sample;
         check("tick spacing", 32'(gap), 32'h13);
         expect_out(0, 16'h1111, 1'b0, 1'b0);
      end
      ctl.send(2, 0);
      next_sample;
      expect_out(0, 16'h0, 1'b0, 1'b1);
      ctl.send(2, 0);
      next_sample;
      expect_out(0, 16'h0, 1'b0, 1'b0);
      $display("test strobed done");
      // Triggered: durations 3, 0 and 2, the last being the edge of off logging.
      foreach (tch[i]) begin
         c = tch[i];
         hi = (duration[c] == 32'h0) ? 1 : int'(duration[c]);
         ctl.send(0, c);
         for (int k = 0; k <= hi; k++) begin
            next_sample;
            expect_out(c, (k < hi) ? high_value[c] : 16'h0, k == 0, k == hi && hi > 2);
         end
      end
      $display("test triggered done");
      // Waveform: four words played in order, then zero; unlogged channel.
      ctl.load(3'h3, w);
      ctl.send(0, 3);
      for (int k = 0; k <= 4; k++) begin
         next_sample;
         expect_out(3, (k < 4) ? w[k] : 16'h0, 1'b0, 1'b0);
      end
      $display("test waveform done");
      // Disabled channel and the unused mode code never start.
      ctl.send(0, 4);
      ctl.send(0, 6);
      repeat (2) begin
         next_sample;
         expect_out(4, 16'h0, 1'b0, 1'b0);
         expect_out(6, 16'h0, 1'b0, 1'b0);
      end
      $display("test idle channels done");
      complete_run();
   end
endmodule
